/* File: shared/ccc_defs.vh */
`ifndef CCC_DEFS_VH
`define CCC_DEFS_VH

// Register offsets
`define CCC_OFS_OSC_CTRL 8'h5D
`define CCC_OFS_OSC_STATE 8'h5E
`define CCC_OFS_RUN_EN 8'h61
`define CCC_OFS_MODE_CFG 8'h62

// Reset values
`define CCC_RST_OSC_CTRL 8'h40
`define CCC_RST_OSC_STATE 8'h00
`define CCC_RST_RUN_EN 8'h01
`define CCC_RST_MODE_CFG 8'h01
`define CCC_RST_TRIM 7'h00

// Field positions
`define CCC_STL_MSB 6
`define CCC_STL_LSB 4
`define CCC_ENGINE_EN_BIT 0
`define CCC_DONE_BIT 0
`define CCC_RUN_EN_BIT 0
`define CCC_BGOS_BIT 3
`define CCC_OS_BIT 2
`define CCC_BG_BIT 1
`define CCC_FG_BIT 0

// Trim search: first trial value and its bit index
`define CCC_TRIM_FIRST 7'h40
`define CCC_TRIM_TOP_IDX 3'h6

// Timing: one settle unit, rounded up to whole clock cycles
`define CCC_CLK_NS 20
`define CCC_SETTLE_UNIT_NS 1000
`define CCC_SETTLE_UNIT_CYC \
	((`CCC_SETTLE_UNIT_NS + `CCC_CLK_NS - 1) / `CCC_CLK_NS)

`endif

/* File: core/ccc_trim_engine.v */
`timescale 1ns/1ps
`include "ccc_defs.vh"

module ccc_trim_engine (
	input wire clk_i,
	input wire sys_rst_i,
	input wire engine_en_i,
	input wire [2:0] settle_sel_i,
	input wire synth_reset_i,
	input wire osc_fast_i,
	input wire trim_load_i,
	input wire [6:0] trim_load_value_i,
	output reg [6:0] trim_o,
	output reg done_o,
	output reg busy_o
);
	localparam E_IDLE = 1'b0;
	localparam E_SETTLE = 1'b1;

	reg state;
	reg synth_reset_q;
	reg [2:0] bit_idx;
	reg [9:0] cnt;
	reg [6:0] mask;
	wire start;
	wire [9:0] target;

	// Settle length in cycles, longer for larger selections
	function [9:0] settle_cycles;
		input [2:0] sel;
		reg [31:0] prod;
		begin
			// Worked out at full width, longest case fits ten bits
			prod = ({29'h0, sel} + 32'h1) * `CCC_SETTLE_UNIT_CYC;
			settle_cycles = prod[9:0];
		end
	endfunction

	assign target = settle_cycles(settle_sel_i);
	// Calibration starts on the release of the synthesizer reset
	assign start = synth_reset_q & ~synth_reset_i & engine_en_i;

	// One-hot mask of the trim bit under trial
	always @* begin
		mask = 7'h01 << bit_idx;
	end

	// Successive approximation of the trim value
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= E_IDLE;
			synth_reset_q <= 1'b0;
			bit_idx <= 3'h0;
			cnt <= 10'h000;
			trim_o <= `CCC_RST_TRIM;
			done_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			synth_reset_q <= synth_reset_i;
			case (state)
			E_IDLE: begin
				if (start) begin
					trim_o <= `CCC_TRIM_FIRST;
					bit_idx <= `CCC_TRIM_TOP_IDX;
					cnt <= 10'h000;
					done_o <= 1'b0;
					busy_o <= 1'b1;
					state <= E_SETTLE;
				end else begin
					if (trim_load_i)
						trim_o <= trim_load_value_i;
					if (synth_reset_i && engine_en_i)
						done_o <= 1'b0;
					else if (!synth_reset_i && !engine_en_i)
						done_o <= 1'b1;
				end
			end
			E_SETTLE: begin
				if (synth_reset_i) begin
					// Aborted: a fresh run follows the next release
					done_o <= 1'b0;
					busy_o <= 1'b0;
					state <= E_IDLE;
				end else if (cnt != target - 10'h001) begin
					cnt <= cnt + 10'h001;
				end else begin
					cnt <= 10'h000;
					// Too fast drops the trial bit, then try the next
					trim_o <= (osc_fast_i ? (trim_o & ~mask) : trim_o) |
						(mask >> 1);
					if (bit_idx == 3'h0) begin
						done_o <= 1'b1;
						busy_o <= 1'b0;
						state <= E_IDLE;
					end else begin
						bit_idx <= bit_idx - 3'h1;
					end
				end
			end
			default: begin
				state <= E_IDLE;
				busy_o <= 1'b0;
			end
			endcase
		end
	end
endmodule

/* File: core/ccc_top.v */
// Operation
// - Engine settles after each trim change; 3-bit field, reset 4.
// - Enabled engine starts when synthesizer reset is written zero.
// - Engine adjusts the trim itself to centre the oscillator frequency.
// - Done bit reads one after calibration finishes or when it was skipped.
// - Global enable, reset one, runs calibration; low holds it in reset.
// - Clearing global enable also resets digital and link clock dividers.
// - Bit 3 enables background offset; set only with background enable.
// - Bit 2 enables foreground offset; set only with foreground select.
// - Bit 1 enables background calibration; reset value zero.
// - Bit 0: clear corrections, then run foreground calibration or skip it.
// - Foreground done rises when foreground calibration ends or is skipped.
`timescale 1ns/1ps
`include "ccc_defs.vh"

module ccc_top (
	input wire clk_i,
	input wire sys_rst_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire synth_reset_i,
	input wire osc_fast_i,
	input wire trim_load_i,
	input wire [6:0] trim_load_value_i,
	output wire [6:0] osc_frequency_trim_o,
	output wire osc_cal_finished_o,
	output wire osc_cal_busy_o,
	input wire fg_complete_i,
	output reg cal_hold_o,
	output reg div_reset_o,
	output reg corr_clear_o,
	output reg fg_run_o,
	output reg fg_offset_run_o,
	output reg bg_run_o,
	output reg bg_offset_run_o,
	output reg foreground_finished_o
);
	localparam C_HOLD = 2'h0;
	localparam C_CLEAR = 2'h1;
	localparam C_FG = 2'h2;
	localparam C_DONE = 2'h3;

	// Whole reset words, so that fields can be sliced out at their width
	localparam [7:0] RST_OSC = `CCC_RST_OSC_CTRL;
	localparam [7:0] RST_RUN = `CCC_RST_RUN_EN;
	localparam [7:0] RST_MODE = `CCC_RST_MODE_CFG;

	// Register fields
	reg [2:0] trim_settle_interval;
	reg osc_cal_engine_enable;
	reg cal_run_enable;
	reg background_offset_enable;
	reg foreground_offset_enable;
	reg background_calibration_enable;
	reg foreground_calibration_select;

	// Converter calibration sequencer
	reg [1:0] cstate;
	reg [1:0] next_cstate;
	reg next_corr_clear;
	reg next_fg_run;
	reg next_bg_run;
	reg next_foreground_finished;

	reg [7:0] next_rdata;
	wire wr_osc_ctrl;
	wire wr_run_en;
	wire wr_mode_cfg;

	// Write strobes per register
	assign wr_osc_ctrl = reg_wr_i && (reg_addr_i == `CCC_OFS_OSC_CTRL);
	assign wr_run_en = reg_wr_i && (reg_addr_i == `CCC_OFS_RUN_EN);
	assign wr_mode_cfg = reg_wr_i && (reg_addr_i == `CCC_OFS_MODE_CFG);

	// Oscillator trim search engine
	ccc_trim_engine u_engine (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.engine_en_i(osc_cal_engine_enable),
		.settle_sel_i(trim_settle_interval),
		.synth_reset_i(synth_reset_i),
		.osc_fast_i(osc_fast_i),
		.trim_load_i(trim_load_i),
		.trim_load_value_i(trim_load_value_i),
		.trim_o(osc_frequency_trim_o),
		.done_o(osc_cal_finished_o),
		.busy_o(osc_cal_busy_o)
	);

	// Software-writable fields; reserved bits are not stored
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			trim_settle_interval <=
				RST_OSC[`CCC_STL_MSB:`CCC_STL_LSB];
			osc_cal_engine_enable <= RST_OSC[`CCC_ENGINE_EN_BIT];
			cal_run_enable <= RST_RUN[`CCC_RUN_EN_BIT];
			background_offset_enable <= RST_MODE[`CCC_BGOS_BIT];
			foreground_offset_enable <= RST_MODE[`CCC_OS_BIT];
			background_calibration_enable <=
				RST_MODE[`CCC_BG_BIT];
			foreground_calibration_select <=
				RST_MODE[`CCC_FG_BIT];
		end else begin
			if (wr_osc_ctrl) begin
				trim_settle_interval <=
					reg_wdata_i[`CCC_STL_MSB:`CCC_STL_LSB];
				osc_cal_engine_enable <=
					reg_wdata_i[`CCC_ENGINE_EN_BIT];
			end
			if (wr_run_en)
				cal_run_enable <= reg_wdata_i[`CCC_RUN_EN_BIT];
			if (wr_mode_cfg) begin
				background_offset_enable <=
					reg_wdata_i[`CCC_BGOS_BIT];
				foreground_offset_enable <=
					reg_wdata_i[`CCC_OS_BIT];
				background_calibration_enable <=
					reg_wdata_i[`CCC_BG_BIT];
				foreground_calibration_select <=
					reg_wdata_i[`CCC_FG_BIT];
			end
		end
	end

	// Read data mux; unmapped offsets read as zero
	always @* begin
		next_rdata = 8'h00;
		case (reg_addr_i)
		`CCC_OFS_OSC_CTRL: begin
			next_rdata[`CCC_STL_MSB:`CCC_STL_LSB] = trim_settle_interval;
			next_rdata[`CCC_ENGINE_EN_BIT] = osc_cal_engine_enable;
		end
		`CCC_OFS_OSC_STATE: begin
			next_rdata[`CCC_DONE_BIT] = osc_cal_finished_o;
		end
		`CCC_OFS_RUN_EN: begin
			next_rdata[`CCC_RUN_EN_BIT] = cal_run_enable;
		end
		`CCC_OFS_MODE_CFG: begin
			next_rdata[`CCC_BGOS_BIT] = background_offset_enable;
			next_rdata[`CCC_OS_BIT] = foreground_offset_enable;
			next_rdata[`CCC_BG_BIT] = background_calibration_enable;
			next_rdata[`CCC_FG_BIT] = foreground_calibration_select;
		end
		default: begin
			next_rdata = 8'h00;
		end
		endcase
	end

	// Read data is captured on the read strobe and held
	always @(posedge clk_i) begin
		if (sys_rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= next_rdata;
	end

	// Sequencer: clear corrections, then foreground run or skip
	always @* begin
		next_cstate = cstate;
		next_corr_clear = 1'b0;
		case (cstate)
		C_HOLD: begin
			if (cal_run_enable) begin
				next_cstate = C_CLEAR;
				next_corr_clear = 1'b1;
			end
		end
		C_CLEAR: begin
			if (foreground_calibration_select)
				next_cstate = C_FG;
			else
				next_cstate = C_DONE;
		end
		C_FG: begin
			if (fg_complete_i)
				next_cstate = C_DONE;
		end
		C_DONE: begin
			next_cstate = C_DONE;
		end
		default: begin
			next_cstate = C_HOLD;
		end
		endcase
		// A low global enable holds the sequence in reset
		if (!cal_run_enable) begin
			next_cstate = C_HOLD;
			next_corr_clear = 1'b0;
		end
		next_fg_run = (next_cstate == C_FG);
		next_foreground_finished = (next_cstate == C_DONE);
		next_bg_run = next_foreground_finished && background_calibration_enable;
	end

	// Registered sequencer state and calibration controls
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cstate <= C_HOLD;
			cal_hold_o <= 1'b1;
			div_reset_o <= 1'b1;
			corr_clear_o <= 1'b0;
			fg_run_o <= 1'b0;
			fg_offset_run_o <= 1'b0;
			bg_run_o <= 1'b0;
			bg_offset_run_o <= 1'b0;
			foreground_finished_o <= 1'b0;
		end else begin
			cstate <= next_cstate;
			cal_hold_o <= ~cal_run_enable;
			div_reset_o <= ~cal_run_enable;
			corr_clear_o <= next_corr_clear;
			fg_run_o <= next_fg_run;
			// Offset parts only act together with their main part
			fg_offset_run_o <= next_fg_run &&
				foreground_offset_enable;
			bg_run_o <= next_bg_run;
			bg_offset_run_o <= next_bg_run &&
				background_offset_enable;
			foreground_finished_o <= next_foreground_finished;
		end
	end
endmodule

/* File: test/ccc_top_props.sv */
`timescale 1ns/1ps
module ccc_props (
	input wire clk_i,
	input wire sys_rst_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire synth_reset_i,
	input wire [6:0] osc_frequency_trim_o,
	input wire osc_cal_finished_o,
	input wire osc_cal_busy_o,
	input wire fg_complete_i,
	input wire cal_hold_o,
	input wire div_reset_o,
	input wire corr_clear_o,
	input wire fg_run_o,
	input wire fg_offset_run_o,
	input wire bg_run_o,
	input wire bg_offset_run_o,
	input wire foreground_finished_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Foreground end: completion seen while running, then done
	sequence s_fg_end;
		fg_run_o && fg_complete_i;
	endsequence
	sequence s_fg_out;
		foreground_finished_o && !fg_run_o;
	endsequence
	// Hold release: one clear pulse
	sequence s_clr;
		corr_clear_o ##1 !corr_clear_o;
	endsequence
	AST_FOREGROUND_FINISHED: assert property (s_fg_end |=> s_fg_out)
		else $error("foreground done late");
	AST_HOLD_EN: assert property (reg_wr_i && reg_addr_i == 8'h61
		&& !reg_wdata_i[0] |-> ##[1:3] cal_hold_o)
		else $error("hold not entered");
	AST_HOLD_DIV: assert property (reg_wr_i && reg_addr_i == 8'h61
		&& !reg_wdata_i[0] |=> ##1 div_reset_o)
		else $error("divider reset not raised");
	AST_HOLD_QUIET: assert property (cal_hold_o |->
		!(fg_run_o || bg_run_o || corr_clear_o))
		else $error("calibration runs in hold");
	AST_BGOS: assert property (bg_offset_run_o |-> bg_run_o)
		else $error("bg offset without bg");
	AST_OS: assert property (fg_offset_run_o |-> fg_run_o)
		else $error("fg offset without fg");
	AST_CLR: assert property ($fell(cal_hold_o) |-> ##[0:2] s_clr)
		else $error("no correction clear pulse");
	AST_OSC_ONE: assert property (osc_cal_busy_o |->
		!osc_cal_finished_o)
		else $error("done while busy");
	AST_OSC_TRIM: assert property ($rose(osc_cal_busy_o) |->
		osc_frequency_trim_o == 7'h40)
		else $error("first trial wrong");
	AST_OSC_ABORT: assert property (synth_reset_i && osc_cal_busy_o
		|=> !osc_cal_busy_o)
		else $error("search not aborted");
endmodule
bind ccc_top ccc_props u_props (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i),
	.synth_reset_i(synth_reset_i),
	.osc_frequency_trim_o(osc_frequency_trim_o),
	.osc_cal_finished_o(osc_cal_finished_o),
	.osc_cal_busy_o(osc_cal_busy_o),
	.fg_complete_i(fg_complete_i),
	.cal_hold_o(cal_hold_o),
	.div_reset_o(div_reset_o),
	.corr_clear_o(corr_clear_o),
	.fg_run_o(fg_run_o),
	.fg_offset_run_o(fg_offset_run_o),
	.bg_run_o(bg_run_o),
	.bg_offset_run_o(bg_offset_run_o),
	.foreground_finished_o(foreground_finished_o)
);

/* File: test/test_ccc_top.sv */
`timescale 1ns/1ps
module test_ccc_top;
	reg clk_i = 0;
	reg sys_rst_i = 1;
	reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
	reg reg_wr_i = 0, reg_rd_i = 0, synth_reset_i = 0, osc_fast_i = 0;
	reg trim_load_i = 0, fg_complete_i = 0;
	reg [6:0] trim_load_value_i = 7'h00, tgt = 7'h00;
	wire [7:0] reg_rdata_o;
	wire [6:0] osc_frequency_trim_o;
	wire osc_cal_finished_o, osc_cal_busy_o, cal_hold_o, div_reset_o;
	wire corr_clear_o, fg_run_o, fg_offset_run_o, bg_run_o;
	wire bg_offset_run_o, foreground_finished_o;
	integer errors = 0, compares = 0, i, n;
	reg [7:0] lf = 8'h06, v;
	ccc_top uut (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.synth_reset_i(synth_reset_i),
		.osc_fast_i(osc_fast_i),
		.trim_load_i(trim_load_i),
		.trim_load_value_i(trim_load_value_i),
		.osc_frequency_trim_o(osc_frequency_trim_o),
		.osc_cal_finished_o(osc_cal_finished_o),
		.osc_cal_busy_o(osc_cal_busy_o),
		.fg_complete_i(fg_complete_i),
		.cal_hold_o(cal_hold_o),
		.div_reset_o(div_reset_o),
		.corr_clear_o(corr_clear_o),
		.fg_run_o(fg_run_o),
		.fg_offset_run_o(fg_offset_run_o),
		.bg_run_o(bg_run_o),
		.bg_offset_run_o(bg_offset_run_o),
		.foreground_finished_o(foreground_finished_o)
	);
	// Clock
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// Comparator: too fast when trial is above target
	always @(posedge clk_i) begin
		osc_fast_i <= osc_frequency_trim_o > tgt;
	end
	// Random source
	function [7:0] nx(input [7:0] s);
		nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Expected background run and offset
	function [7:0] bgx(input [7:0] c);
		bgx = {6'h00, c[1], c[1] & c[3]};
	endfunction
	task ck(input [7:0] g, input [7:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task tick(input integer k);
		begin
			repeat (k) @(posedge clk_i);
			#1;
		end
	endtask
	task wr(input [7:0] ad, input [7:0] wd);
		begin
			@(posedge clk_i);
			reg_addr_i <= ad;
			reg_wdata_i <= wd;
			reg_wr_i <= 1;
			@(posedge clk_i);
			reg_wr_i <= 0;
		end
	endtask
	task rd(input [7:0] ad, input [7:0] e);
		begin
			@(posedge clk_i);
			reg_addr_i <= ad;
			reg_rd_i <= 1;
			@(posedge clk_i);
			reg_rd_i <= 0;
			#1;
			ck(reg_rdata_o, e);
		end
	endtask
	task report_and_stop;
		begin
			$display("compares %0d errors %0d", compares, errors);
			if (errors == 0 && compares > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 0;
		rd(8'h5D, 8'h40);
		rd(8'h5E, 8'h01);
		rd(8'h61, 8'h01);
		rd(8'h62, 8'h01);
		rd(8'h70, 8'h00);
		ck({7'h00, fg_run_o}, 8'h01);
		$display("test registers done");
		for (i = 0; i < 16; i = i + 1) begin
			v = i;
			v[3] = v[3] & v[1];
			v[2] = v[2] & v[0];
			wr(8'h61, 8'h00);
			tick(1);
			ck({cal_hold_o, div_reset_o}, 8'h03);
			wr(8'h62, v);
			rd(8'h62, v);
			wr(8'h61, 8'h01);
			tick(1);
			ck({7'h00, corr_clear_o}, 8'h01);
			tick(2);
			ck({fg_run_o, fg_offset_run_o}, {v[0], v[2]});
			lf = nx(lf);
			tick(lf[2:0]);
			@(posedge clk_i);
			fg_complete_i <= 1;
			tick(3);
			ck({5'h00, foreground_finished_o, bg_run_o, bg_offset_run_o},
				bgx(v) | 8'h04);
			@(posedge clk_i);
			fg_complete_i <= 0;
		end
		$display("test modes done");
		for (i = 0; i < 3; i = i + 1) begin
			lf = nx(lf);
			tgt = lf[6:0];
			v = {1'b0, (i == 1) ? 3'h7 : lf[2:0], 4'h1};
			@(posedge clk_i);
			synth_reset_i <= 1;
			wr(8'h5D, v);
			rd(8'h5D, v);
			rd(8'h5E, 8'h00);
			@(posedge clk_i);
			synth_reset_i <= 0;
			tick(20);
			ck({7'h00, osc_cal_busy_o}, 8'h01);
			@(posedge clk_i);
			synth_reset_i <= 1;
			tick(2);
			ck({osc_cal_busy_o, osc_cal_finished_o}, 8'h00);
			@(posedge clk_i);
			synth_reset_i <= 0;
			tick(7 * (v[6:4] + 1) * 50 - 3);
			ck({7'h00, osc_cal_finished_o}, 8'h00);
			n = 0;
			while (osc_cal_finished_o !== 1'b1 && n < 8) begin
				tick(1);
				n = n + 1;
			end
			ck({7'h00, osc_cal_finished_o}, 8'h01);
			ck(osc_frequency_trim_o, tgt);
		end
		@(posedge clk_i);
		trim_load_i <= 1;
		trim_load_value_i <= ~tgt;
		@(posedge clk_i);
		trim_load_i <= 0;
		tick(1);
		ck({1'b0, osc_frequency_trim_o}, {1'b0, ~tgt});
		$display("test oscillator done");
		report_and_stop;
	end
endmodule
